// ### smt_host.sv
/*
 host model on the register port.
 assumes requests launched on the falling edge of core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module smt_host import smt_pkg::*; (
    input  wire logic     core_clk,
    output var  smt_bus_t bus
);
    initial bus = '0;
    // one request held over exactly one rising edge
    task automatic xfer(input logic w, input logic [7:0] a, d);
        @(negedge core_clk);
        bus <= {1'b1, w, a, d};
        @(negedge core_clk);
        bus <= {1'b0, 1'b0, ~a, ~d};
    endtask
endmodule // smt_host
`default_nettype wire

// ### smt_pkg.sv
/*
 package for the supply monitor and trim register block.
 assumes a byte-wide register port with address, write strobe and read data.
*/
`default_nettype none
package smt_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] SMT_ADDR_MAIN_SUPPLY = 8'h09;
    localparam logic [7:0] SMT_ADDR_BATT_TRIP   = 8'h0a;
    localparam logic [7:0] SMT_ADDR_TRIM        = 8'h0b;
    localparam logic [7:0] SMT_ADDR_STATUS      = 8'h07;

    localparam int SMT_CLEAR_BIT   = 7;
    localparam int SMT_DISCON_BIT  = 6;
    localparam int SMT_TRIM_LSB    = 6;

    localparam logic [7:0] SMT_MAIN_RESET = 8'h00;
    localparam logic [7:0] SMT_BATT_RESET = 8'h00;
    localparam logic [7:0] SMT_TRIM_RESET = 8'h00;
    localparam logic [7:0] SMT_MAIN_MASK  = 8'h87;
    localparam logic [7:0] SMT_BATT_MASK  = 8'h7f;

    // status bit positions
    localparam int SMT_ST_MAIN_LOW  = 3;
    localparam int SMT_ST_BATT1_LOW = 2;
    localparam int SMT_ST_BATT2_LOW = 1;

    // ---------------------------------------------------------------
    // trip codes
    // ---------------------------------------------------------------
    localparam logic [2:0] SMT_MAIN_CODE_MAX = 3'h5;
    localparam logic [2:0] SMT_BATT_CODE_MAX = 3'h6;

    // trim: prescaler of 32768 counts per second; 30.5 ppm is one count
    // in the 32768-count second, applied once per one-second period
    localparam int SMT_TICKS_PER_SEC = 32768;
    localparam logic [15:0] SMT_TICK_LAST = 16'h7fff;

    typedef enum logic [1:0] {
        SMT_TRIM_OFF  = 2'b00,
        SMT_TRIM_PLUS = 2'b01,
        SMT_TRIM_ZERO = 2'b10,
        SMT_TRIM_MINUS = 2'b11
    } smt_trim_t;

    typedef struct packed {
        logic       req;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } smt_bus_t;

    typedef struct packed {
        logic main_low;
        logic batt1_low;
        logic batt2_low;
    } smt_cmp_t;

    // per-level trip comparator input: comparator outputs, one per code
    typedef struct packed {
        logic [5:0] main_below;
        logic [6:0] batt1_below;
        logic [6:0] batt2_below;
    } smt_levels_t;

    function automatic logic smt_pick(input logic [6:0] below,
                                      input logic [2:0] code,
                                      input logic [2:0] code_max);
        smt_pick = (code <= code_max) ? below[code] : 1'b0;
    endfunction
endpackage
`default_nettype wire

// ### smt_regs.sv
/*
 supply monitor and trim registers: supply control, battery trip control,
 initial trim setting, and the supply-related status flags.
 assumes a byte register port on core_clk, comparator levels from pins.
*/
// What this block does
// - setting stamp-clear bit clears both switchover stamps; bit resets zero.
// - main trip select picks one of six brownout levels.
// - main supply below chosen level sets main-supply-low flag.
// - writing one to disconnect bit detaches battery pin.
// - main supply power cycle clears disconnect bit, reconnects battery.
// - first battery trip select picks one of seven levels.
// - second battery trip select picks one of seven levels.
// - any of seven codes accepted without nominal battery check.
// - coarse trim codes: off, plus 30.5, zero, minus 30.5 ppm.
// - trim skips or inserts chain pulses, oscillator untouched.
// - digital plus analog trim spans +62.5 to -61.5 ppm.
// - battery below first level sets first low-battery flag.
// - battery below second level sets second low-battery flag.
`timescale 1ns/1ns
`default_nettype none
module smt_regs import smt_pkg::*; (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire smt_bus_t    bus_in,
    output var  logic [7:0]  rdata,
    input  wire smt_levels_t levels_in,
    input  wire logic        main_power_good,
    input  wire logic        status_clear,
    input  wire logic [5:0]  fine_analog_trim,
    input  wire logic        osc_tick,
    output var  logic        stamp_clear_pulse,
    output var  logic        battery_connect,
    output var  logic [2:0]  main_supply_trip_sel,
    output var  logic [2:0]  battery_first_trip_sel,
    output var  logic [2:0]  battery_second_trip_sel,
    output var  logic [1:0]  coarse_digital_trim,
    output var  logic [5:0]  analog_trim_out,
    output var  smt_cmp_t    flags,
    output var  logic        sec_tick
);
    typedef struct packed {
        logic [7:0]  main_ctl;
        logic [7:0]  batt_ctl;
        logic [7:0]  trim;
        smt_cmp_t    flags;
        logic        clear_pulse;
        logic        pg_seen_low;
        smt_levels_t lv_s1;
        smt_levels_t lv_s2;
        logic        pg_s1;
        logic        pg_s2;
        logic [7:0]  rdata;
    } smt_state_t;

    smt_state_t st_reg;
    smt_state_t st_next;
    logic       wr_main;
    logic       wr_batt;
    logic       wr_trim;
    smt_cmp_t   below;

    assign wr_main = bus_in.req && bus_in.write
                     && (bus_in.addr == SMT_ADDR_MAIN_SUPPLY);
    assign wr_batt = bus_in.req && bus_in.write
                     && (bus_in.addr == SMT_ADDR_BATT_TRIP);
    assign wr_trim = bus_in.req && bus_in.write
                     && (bus_in.addr == SMT_ADDR_TRIM);

    // ---------------------------------------------------------------
    // trip level selection from synchronised comparators
    // ---------------------------------------------------------------
    always_comb begin
        below.main_low  = smt_pick({1'b0, st_reg.lv_s2.main_below},
                                   st_reg.main_ctl[2:0],
                                   SMT_MAIN_CODE_MAX);
        below.batt1_low = smt_pick(st_reg.lv_s2.batt1_below,
                                   st_reg.batt_ctl[5:3],
                                   SMT_BATT_CODE_MAX);
        below.batt2_low = smt_pick(st_reg.lv_s2.batt2_below,
                                   st_reg.batt_ctl[2:0],
                                   SMT_BATT_CODE_MAX);
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.lv_s1 = levels_in;
        st_next.lv_s2 = st_reg.lv_s1;
        st_next.pg_s1 = main_power_good;
        st_next.pg_s2 = st_reg.pg_s1;
        st_next.clear_pulse = 1'b0;

        if (wr_main) begin
            st_next.main_ctl = bus_in.wdata & SMT_MAIN_MASK;
        end
        if (wr_batt) begin
            st_next.batt_ctl = bus_in.wdata & SMT_BATT_MASK;
        end
        if (wr_trim) begin
            st_next.trim = bus_in.wdata;
        end

        // stamp clear acts once, then the bit falls back to zero
        if (st_reg.main_ctl[SMT_CLEAR_BIT]) begin
            st_next.clear_pulse = 1'b1;
            if (!wr_main) begin
                st_next.main_ctl[SMT_CLEAR_BIT] = 1'b0;
            end
        end

        // main supply power cycle ends the disconnect
        if (!st_reg.pg_s2) begin
            st_next.pg_seen_low = 1'b1;
        end else if (st_reg.pg_seen_low) begin
            st_next.pg_seen_low = 1'b0;
            st_next.batt_ctl[SMT_DISCON_BIT] = 1'b0;
        end

        // sticky flags: set wins over clear
        if (status_clear) begin
            st_next.flags = '0;
        end
        if (below.main_low) begin
            st_next.flags.main_low = 1'b1;
        end
        if (below.batt1_low) begin
            st_next.flags.batt1_low = 1'b1;
        end
        if (below.batt2_low) begin
            st_next.flags.batt2_low = 1'b1;
        end

        st_next.rdata = 8'h00;
        if (bus_in.req && !bus_in.write) begin
            case (bus_in.addr)
                SMT_ADDR_MAIN_SUPPLY: st_next.rdata = st_reg.main_ctl;
                SMT_ADDR_BATT_TRIP:   st_next.rdata = st_reg.batt_ctl;
                SMT_ADDR_TRIM: begin
                    st_next.rdata = {st_reg.trim[7:SMT_TRIM_LSB],
                                     fine_analog_trim};
                end
                SMT_ADDR_STATUS: begin
                    st_next.rdata[SMT_ST_MAIN_LOW]  = st_reg.flags.main_low;
                    st_next.rdata[SMT_ST_BATT1_LOW] = st_reg.flags.batt1_low;
                    st_next.rdata[SMT_ST_BATT2_LOW] = st_reg.flags.batt2_low;
                end
                default: st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_reg          <= '0;
            st_reg.main_ctl <= SMT_MAIN_RESET;
            st_reg.batt_ctl <= SMT_BATT_RESET;
            st_reg.trim     <= SMT_TRIM_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign rdata                   = st_reg.rdata;
    assign stamp_clear_pulse       = st_reg.clear_pulse;
    assign battery_connect         = !st_reg.batt_ctl[SMT_DISCON_BIT];
    assign main_supply_trip_sel    = st_reg.main_ctl[2:0];
    assign battery_first_trip_sel  = st_reg.batt_ctl[5:3];
    assign battery_second_trip_sel = st_reg.batt_ctl[2:0];
    assign coarse_digital_trim     = st_reg.trim[7:SMT_TRIM_LSB];
    // analog trim field passes through to the oscillator load; with the
    // coarse step this spans the full correction range
    assign analog_trim_out         = fine_analog_trim;
    assign flags                   = st_reg.flags;

    smt_trim_chain u_chain (
        .core_clk  (core_clk),
        .reset     (reset),
        .osc_tick  (osc_tick),
        .trim_code (st_reg.trim[7:SMT_TRIM_LSB]),
        .sec_tick  (sec_tick)
    );
endmodule // smt_regs
`default_nettype wire

// ### smt_regs_monitor.sv
/*
 checker on the ports of smt_regs.
 assumes the byte register port contract of the block.
*/
`timescale 1ns/1ns
`default_nettype none
module smt_regs_monitor import smt_pkg::*; (
    input wire logic       core_clk,
    input wire logic       reset,
    input wire smt_bus_t   bus_in,
    input wire logic [7:0] rdata,
    input wire logic       stamp_clear_pulse,
    input wire logic       battery_connect,
    input wire logic [2:0] main_supply_trip_sel,
    input wire logic [2:0] battery_first_trip_sel,
    input wire logic [2:0] battery_second_trip_sel,
    input wire logic [1:0] coarse_digital_trim,
    input wire logic [5:0] fine_analog_trim,
    input wire logic [5:0] analog_trim_out,
    input wire smt_cmp_t   flags,
    input wire logic       status_clear,
    input wire logic       sec_tick
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    wire logic wr = bus_in.req && bus_in.write;
    wire logic rd = bus_in.req && !bus_in.write;
    wire logic [7:0] a = bus_in.addr;

    AST_STAMP: assert property (
        wr && a == 8'h09 && bus_in.wdata[7] |-> ##2 stamp_clear_pulse)
        else $error("stamp clear pulse missing");
    AST_STAMP_ONE: assert property (
        stamp_clear_pulse |=> !stamp_clear_pulse)
        else $error("stamp clear pulse too long");
    AST_MAIN_SEL: assert property (
        wr && a == 8'h09 |=> main_supply_trip_sel == $past(bus_in.wdata[2:0]))
        else $error("main trip select not taken");
    AST_BATT_SEL: assert property (
        wr && a == 8'h0a |=>
        {battery_first_trip_sel, battery_second_trip_sel}
            == $past(bus_in.wdata[5:0]))
        else $error("battery trip selects not taken");
    AST_DISCON: assert property (
        wr && a == 8'h0a && bus_in.wdata[6] |=> !battery_connect)
        else $error("battery not disconnected");
    AST_TRIM: assert property (
        wr && a == 8'h0b |=> coarse_digital_trim == $past(bus_in.wdata[7:6]))
        else $error("coarse trim not taken");
    AST_ZERO_BITS: assert property (
        rd && a == 8'h09 |=> rdata[6:3] == 4'h0)
        else $error("supply control spare bits not zero");
    AST_UNMAPPED: assert property (
        rd && !(a inside {8'h07, 8'h09, 8'h0a, 8'h0b}) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_ANALOG: assert property (
        analog_trim_out == fine_analog_trim)
        else $error("analog trim not passed through");
    AST_STICKY: assert property (
        flags.main_low && !status_clear |=> flags.main_low)
        else $error("main low flag dropped");
    AST_SEC_ONE: assert property (
        sec_tick |=> !sec_tick)
        else $error("second tick too long");
    cover property (stamp_clear_pulse);
    cover property (!battery_connect);
    cover property (flags.batt2_low);
    cover property (sec_tick);
endmodule // smt_regs_monitor
`default_nettype wire

// ### smt_trim_chain.sv
/*
 coarse digital trim of the one-second timekeeping chain.
 assumes osc_tick is a one-cycle pulse per oscillator period, same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module smt_trim_chain import smt_pkg::*; (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       osc_tick,
    input  wire logic [1:0] trim_code,
    output var  logic       sec_tick
);
    typedef struct packed {
        logic [15:0] count;
        logic        pulse;
    } smt_chain_t;

    smt_chain_t st_reg;
    smt_chain_t st_next;
    smt_trim_t  mode;

    assign mode = smt_trim_t'(trim_code);

    // ---------------------------------------------------------------
    // pulse skip or insert once per second
    // ---------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.pulse = 1'b0;
        if (osc_tick) begin
            if (st_reg.count == SMT_TICK_LAST) begin
                st_next.pulse = 1'b1;
                case (mode)
                    // inserted pulse: next second one count short
                    SMT_TRIM_PLUS: st_next.count = 16'h0001;
                    // skipped pulse: next second one count long
                    SMT_TRIM_MINUS: st_next.count = 16'hffff;
                    default: st_next.count = 16'h0000;
                endcase
            end else begin
                st_next.count = st_reg.count + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sec_tick = st_reg.pulse;
endmodule // smt_trim_chain
`default_nettype wire

// ### supply_monitor_trim_regs_tb.sv
/*
 self-checking bench for smt_regs.
 assumes smt_host and smt_regs_monitor beside it.
*/
`timescale 1ns/1ns
`default_nettype none
module supply_monitor_trim_regs_tb import smt_pkg::*;;
    logic core_clk = 0, reset = 1, status_clear = 0, osc_tick = 1;
    logic main_power_good = 1, rd_seen = 0, stamp, b_conn, tick;
    logic [5:0] fine_trim, a_out;
    logic [2:0] m_sel, b1_sel, b2_sel;
    logic [1:0] c_trim;
    logic [7:0] rdata, exp_q[$];
    smt_levels_t levels = '0;
    smt_bus_t bus;
    smt_cmp_t flags;
    int num_errors = 0, compares = 0, seed = 32'h4176;
    always #20 core_clk = ~core_clk;
    smt_host u_host (.core_clk(core_clk), .bus(bus));
    smt_regs u_dut (.core_clk(core_clk), .reset(reset), .bus_in(bus),
        .rdata(rdata), .levels_in(levels), .main_power_good(main_power_good),
        .status_clear(status_clear), .fine_analog_trim(fine_trim),
        .osc_tick(osc_tick), .stamp_clear_pulse(stamp),
        .battery_connect(b_conn), .main_supply_trip_sel(m_sel),
        .battery_first_trip_sel(b1_sel), .battery_second_trip_sel(b2_sel),
        .coarse_digital_trim(c_trim), .analog_trim_out(a_out),
        .flags(flags), .sec_tick(tick));
    task automatic chk(input string n, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        u_host.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, e);
        exp_q.push_back(e);
        u_host.xfer(1'b0, a, 8'h00);
    endtask
    task automatic wrap_up;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // read data lands on the read edge itself and is checked at the next falling edge
    always @(posedge core_clk) rd_seen <= bus.req && !bus.write;
    always @(negedge core_clk) begin
        if (rd_seen) chk("rdata", exp_q.pop_front(), rdata);
    end
    initial begin
        #(90000 * 40);
        num_errors++;
        wrap_up();
    end
    initial begin : main
        logic [7:0] d;
        int t;
        fine_trim = 6'($random(seed));
        repeat (2) @(posedge core_clk);
        @(negedge core_clk) reset = 0;
        rd(8'h09, 8'h00);
        rd(8'h0a, 8'h00);
        rd(8'h0b, {2'b00, fine_trim});
        rd(8'h07, 8'h00);
        rd(8'h3c, 8'h00);
        chk("a_trim", {2'b00, fine_trim}, {2'b00, a_out});
        $display("done: reset values");
        for (int i = 0; i < 8; i++) begin
            d = {1'b1, 4'($random(seed)), 3'(i)};
            wr(8'h09, d);
            @(negedge core_clk);
            chk("stamp", 8'h01, {7'h0, stamp});
            rd(8'h09, {5'h00, d[2:0]});
            chk("main_sel", {5'h0, d[2:0]}, {5'h0, m_sel});
            d = {1'($random(seed)), 1'b0, 3'(i), 3'(7 - i)};
            wr(8'h0a, d);
            rd(8'h0a, {1'b0, d[6:0]});
            chk("b_sel", {2'h0, d[5:0]}, {2'h0, b1_sel, b2_sel});
        end
        $display("done: trip selects");
        wr(8'h09, 8'h06);
        wr(8'h0a, 8'h2b);
        levels = {6'h3f, ~7'h20, ~7'h08};
        repeat (5) @(negedge core_clk);
        rd(8'h07, 8'h00);
        wr(8'h09, 8'h02);
        levels = {6'h04, 7'h20, 7'h08};
        repeat (5) @(negedge core_clk);
        rd(8'h07, 8'h0e);
        chk("flags", 8'h07, {5'h00, flags});
        levels = '0;
        repeat (4) @(negedge core_clk);
        status_clear = 1;
        @(negedge core_clk);
        status_clear = 0;
        rd(8'h07, 8'h00);
        $display("done: flags");
        wr(8'h0a, 8'h40);
        chk("connect", 8'h00, {7'h0, b_conn});
        main_power_good = 0;
        repeat (6) @(negedge core_clk);
        main_power_good = 1;
        repeat (8) @(negedge core_clk);
        rd(8'h0a, 8'h00);
        chk("connect", 8'h01, {7'h0, b_conn});
        $display("done: power cycle");
        for (int i = 0; i < 4; i++) begin
            fine_trim = 6'($random(seed));
            d = {2'(i + 2), 6'($random(seed))};
            wr(8'h0b, d);
            rd(8'h0b, {d[7:6], fine_trim});
            chk("trim", {6'h0, d[7:6]}, {6'h0, c_trim});
            chk("a_trim", {2'b00, fine_trim}, {2'b00, a_out});
        end
        while (tick !== 1'b1) @(negedge core_clk);
        t = 0;
        do begin
            @(negedge core_clk);
            t++;
        end while (tick !== 1'b1 && t < 40000);
        chk("sec_len", 8'h00, 8'(t - (SMT_TICKS_PER_SEC - 1)));
        $display("done: trim");
        wrap_up();
    end
endmodule // supply_monitor_trim_regs_tb
bind smt_regs smt_regs_monitor u_mon (.core_clk(core_clk), .reset(reset),
    .bus_in(bus_in), .rdata(rdata), .stamp_clear_pulse(stamp_clear_pulse),
    .battery_connect(battery_connect),
    .main_supply_trip_sel(main_supply_trip_sel),
    .battery_first_trip_sel(battery_first_trip_sel),
    .battery_second_trip_sel(battery_second_trip_sel),
    .coarse_digital_trim(coarse_digital_trim),
    .fine_analog_trim(fine_analog_trim), .analog_trim_out(analog_trim_out),
    .flags(flags), .status_clear(status_clear), .sec_tick(sec_tick));
`default_nettype wire
